/* File: verilog/polarity_detect_pkg.sv */
// Constants for the output polarity, identification and clock detect registers
package polarity_detect_pkg;
  localparam logic [7:0] polarity_offset = 8'h57;
  localparam logic [7:0] identification_offset = 8'h58;
  localparam logic [7:0] detect_offset = 8'h5B;
  localparam logic [7:0] polarity_reset = 8'h00;
  localparam logic [7:0] detect_reset = 8'h00;
  localparam logic [7:0] read_zero = 8'h00;
  // Arbitrary neutral identification value
  localparam logic [7:0] chip_identification_value = 8'h5A;
  localparam int second_pin_invert_bit = 5;
  localparam int mute_invert_bit = 4;
  localparam int first_pin_invert_bit = 3;
  localparam int rate_field_msb = 6;
  localparam int rate_field_lsb = 4;
  localparam int ratio_field_msb = 3;
  localparam int ratio_field_lsb = 0;
  localparam logic [2:0] rate_error = 3'h0;
  localparam logic [2:0] rate_8k = 3'h1;
  localparam logic [2:0] rate_16k = 3'h2;
  localparam logic [2:0] rate_32_48k = 3'h3;
  localparam logic [2:0] rate_88_96k = 3'h4;
  localparam logic [2:0] rate_176_192k = 3'h5;
  localparam logic [2:0] rate_384k = 3'h6;
  localparam logic [3:0] ratio_error = 4'h0;
  localparam logic [3:0] ratio_max_code = 4'hE;
  // Least ratio, as a multiple of the sample rate, that leaves enough processor cycles with the PLL off
  localparam logic [11:0] min_ratio_without_pll = 12'h100;
endpackage

/* File: verilog/output_polarity_clock_detect_regs.sv */
// Output polarity register, identification register and detected clock status register
`timescale 1ns/100ps
// Operation
// RULE1: Bit 5 inverts second general pin output
// RULE2: Bit 4 inverts mute pin output
// RULE3: Bit 3 inverts first general pin output
// RULE4: Read-only fixed identification register, writes ignored
// RULE5: Bits 6-4 report detected sampling rate code
// RULE6: Bits 3-0 report ratio, 0000 not permitted
// RULE7: Clock error on incompatible ratio and rate
// RULE8: Source must give enough ratio without PLL
// RULE9: Source keeps master clock below 50 MHz
// RULE10: Ratio codes 1 to 14 map 32..3072
// RULE11: Status fields track detector, reads side-effect free
module output_polarity_clock_detect_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  // Register strobe port fed by the control interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Selected pin sources and the pin levels after polarity
  input wire logic first_pin_source,
  input wire logic second_pin_source,
  input wire logic mute_source,
  output logic first_general_pin,
  output logic second_general_pin,
  output logic mute_pin,
  // Clock detector results
  input wire logic [2:0] rate_detect_in,
  input wire logic [3:0] ratio_detect_in,
  input wire logic pll_enabled,
  input wire logic mclk_over_limit,
  output logic clock_error
);
  logic [7:0] output_polarity_control;
  logic [2:0] detected_sample_rate_field;
  logic [3:0] detected_clock_ratio_field;
  logic [2:0] next_rate;
  logic [3:0] next_ratio;
  logic next_clock_error;
  logic [7:0] next_rdata;

  // Master clock multiple of the sample rate for a ratio code
  function automatic logic [11:0] ratio_multiple(input logic [3:0] code);
    unique case (code)
      4'h1: ratio_multiple = 12'h020;
      4'h2: ratio_multiple = 12'h030;
      4'h3: ratio_multiple = 12'h040;
      4'h4: ratio_multiple = 12'h080;
      4'h5: ratio_multiple = 12'h0C0;
      4'h6: ratio_multiple = 12'h100;
      4'h7: ratio_multiple = 12'h180;
      4'h8: ratio_multiple = 12'h200;
      4'h9: ratio_multiple = 12'h300;
      4'hA: ratio_multiple = 12'h400;
      4'hB: ratio_multiple = 12'h480;
      4'hC: ratio_multiple = 12'h600;
      4'hD: ratio_multiple = 12'h800;
      4'hE: ratio_multiple = 12'hC00;
      default: ratio_multiple = 12'h000;
    endcase
  endfunction

  // Polarity register; reserved bits are kept as written
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      output_polarity_control <= polarity_detect_pkg::polarity_reset;
    end else if (reg_write && reg_addr == polarity_detect_pkg::polarity_offset) begin
      output_polarity_control <= reg_wdata;
    end
  end

  // Pin drivers with selectable inversion
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      first_general_pin <= 1'b0;
      second_general_pin <= 1'b0;
      mute_pin <= 1'b0;
    end else begin
      second_general_pin <= second_pin_source ^ output_polarity_control[polarity_detect_pkg::second_pin_invert_bit]; // [RULE1]
      mute_pin <= mute_source ^ output_polarity_control[polarity_detect_pkg::mute_invert_bit]; // [RULE2]
      first_general_pin <= first_pin_source ^ output_polarity_control[polarity_detect_pkg::first_pin_invert_bit]; // [RULE3]
    end
  end

  // Illegal detector codes are reported as the error codes
  // Without the PLL a low ratio leaves too few processor cycles, so it is an error
  always_comb begin
    next_rate = (rate_detect_in > polarity_detect_pkg::rate_384k) ?
      polarity_detect_pkg::rate_error : rate_detect_in; // [RULE5]
    next_ratio = (ratio_detect_in > polarity_detect_pkg::ratio_max_code) ?
      polarity_detect_pkg::ratio_error : ratio_detect_in; // [RULE6] [RULE10]
    next_clock_error = (next_rate == polarity_detect_pkg::rate_error) ||
      (next_ratio == polarity_detect_pkg::ratio_error) || mclk_over_limit || // [RULE9]
      (!pll_enabled && ratio_multiple(next_ratio) < polarity_detect_pkg::min_ratio_without_pll); // [RULE7] [RULE8]
  end

  // Status follows the detector every cycle, independent of reads
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      detected_sample_rate_field <= polarity_detect_pkg::rate_error;
      detected_clock_ratio_field <= polarity_detect_pkg::ratio_error;
      clock_error <= 1'b0;
    end else begin
      detected_sample_rate_field <= next_rate; // [RULE11]
      detected_clock_ratio_field <= next_ratio; // [RULE11]
      clock_error <= next_clock_error; // [RULE7]
    end
  end

  // Read mux; reserved status bit and unmapped addresses read as zero
  always_comb begin
    next_rdata = polarity_detect_pkg::read_zero;
    unique case (reg_addr)
      polarity_detect_pkg::polarity_offset: next_rdata = output_polarity_control;
      polarity_detect_pkg::identification_offset: next_rdata = polarity_detect_pkg::chip_identification_value; // [RULE4]
      polarity_detect_pkg::detect_offset: begin
        next_rdata[polarity_detect_pkg::rate_field_msb:polarity_detect_pkg::rate_field_lsb] =
          detected_sample_rate_field; // [RULE5]
        next_rdata[polarity_detect_pkg::ratio_field_msb:polarity_detect_pkg::ratio_field_lsb] =
          detected_clock_ratio_field; // [RULE6]
      end
      default: next_rdata = polarity_detect_pkg::read_zero;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= polarity_detect_pkg::read_zero;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks run on the core clock and pause while reset is held
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Each pin shows its source of the cycle before, inverted by its polarity bit
  chk_second_pin_invert: assert property ($past(reset_n) |-> // [RULE1]
    second_general_pin == ($past(second_pin_source) ^
    $past(output_polarity_control[polarity_detect_pkg::second_pin_invert_bit])))
    else $error("second pin polarity wrong");
  chk_mute_invert: assert property ($past(reset_n) |-> // [RULE2]
    mute_pin == ($past(mute_source) ^ $past(output_polarity_control[polarity_detect_pkg::mute_invert_bit])))
    else $error("mute pin polarity wrong");
  chk_first_pin_invert: assert property ($past(reset_n) |-> // [RULE3]
    first_general_pin == ($past(first_pin_source) ^
    $past(output_polarity_control[polarity_detect_pkg::first_pin_invert_bit])))
    else $error("first pin polarity wrong");
  chk_polarity_reset: assert property ($rose(reset_n) |-> // [RULE1] [RULE2] [RULE3]
    output_polarity_control == polarity_detect_pkg::polarity_reset &&
    !first_general_pin && !second_general_pin && !mute_pin)
    else $error("polarity or pins not cleared by reset");

  // Register access
  chk_polarity_write: assert property (reg_write && reg_addr == polarity_detect_pkg::polarity_offset |=> // [RULE1]
    output_polarity_control == $past(reg_wdata))
    else $error("polarity write not stored");
  chk_id_read: assert property (reg_read && reg_addr == polarity_detect_pkg::identification_offset |=> // [RULE4]
    reg_rdata == polarity_detect_pkg::chip_identification_value)
    else $error("identification read wrong");
  chk_id_no_write: assert property (reg_write && reg_addr == polarity_detect_pkg::identification_offset |=> // [RULE4]
    $stable(output_polarity_control))
    else $error("identification write had effect");
  chk_detect_no_write: assert property (reg_write && reg_addr == polarity_detect_pkg::detect_offset |=> // [RULE6]
    $stable(output_polarity_control))
    else $error("status write had effect");
  chk_status_read: assert property (reg_read && reg_addr == polarity_detect_pkg::detect_offset |=> // [RULE5] [RULE6]
    reg_rdata == {1'h0, $past(detected_sample_rate_field), $past(detected_clock_ratio_field)})
    else $error("status read wrong");
  chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata)) // [RULE11]
    else $error("read data changed without a read");

  // Status fields and clock error flag
  chk_rate_field: assert property (reg_read && reg_addr == polarity_detect_pkg::detect_offset && // [RULE5]
    rate_detect_in == 3'h7 && $stable(rate_detect_in) |=>
    reg_rdata[polarity_detect_pkg::rate_field_msb:polarity_detect_pkg::rate_field_lsb] ==
    polarity_detect_pkg::rate_error && !reg_rdata[polarity_detect_pkg::rate_field_msb + 1])
    else $error("illegal rate not reported as error");
  chk_ratio_field: assert property (ratio_detect_in == 4'hF |=> // [RULE6]
    detected_clock_ratio_field == polarity_detect_pkg::ratio_error)
    else $error("illegal ratio not reported as error");
  chk_ratio_legal: assert property (detected_clock_ratio_field <= polarity_detect_pkg::ratio_max_code) // [RULE10]
    else $error("ratio field shows an undefined code");
  chk_rate_legal: assert property (detected_sample_rate_field <= polarity_detect_pkg::rate_384k) // [RULE5]
    else $error("rate field shows an undefined code");
  chk_rate_error_flag: assert property (rate_detect_in == polarity_detect_pkg::rate_error |=> clock_error) // [RULE5]
    else $error("rate error without clock error");
  chk_ratio_error_flag: assert property (ratio_detect_in == polarity_detect_pkg::ratio_error |=> // [RULE6]
    clock_error)
    else $error("zero ratio without clock error");
  chk_over_limit_flag: assert property (mclk_over_limit |=> clock_error) // [RULE9]
    else $error("fast master clock not flagged");
  chk_incompatible_flag: assert property (!pll_enabled && ratio_detect_in == 4'h3 |=> clock_error) // [RULE7]
    else $error("low ratio without PLL not flagged");
  chk_pll_ratio_floor: assert property (!pll_enabled && ratio_detect_in == 4'h5 |=> clock_error) // [RULE8]
    else $error("ratio below floor without PLL not flagged");
  chk_good_clock: assert property (pll_enabled && ratio_detect_in == 4'hD && rate_detect_in == 3'h3 && // [RULE10]
    !mclk_over_limit |=> !clock_error)
    else $error("valid clock flagged");
  chk_fast_rate_ok: assert property (pll_enabled && ratio_detect_in == 4'h8 && rate_detect_in == 3'h6 && // [RULE5]
    !mclk_over_limit |=> !clock_error)
    else $error("valid fast rate flagged");
  chk_floor_ratio_ok: assert property (!pll_enabled && ratio_detect_in == 4'h6 && rate_detect_in == 3'h3 && // [RULE10]
    !mclk_over_limit |=> !clock_error)
    else $error("ratio at floor without PLL flagged");
  chk_status_track: assert property (##1 $stable(rate_detect_in) [*2] |-> // [RULE11]
    detected_sample_rate_field == (rate_detect_in == 3'h7 ? polarity_detect_pkg::rate_error : rate_detect_in))
    else $error("rate field not tracking detector");
  chk_ratio_track: assert property (##1 $stable(ratio_detect_in) [*2] |-> // [RULE11]
    detected_clock_ratio_field == (ratio_detect_in == 4'hF ? polarity_detect_pkg::ratio_error : ratio_detect_in))
    else $error("ratio field not tracking detector");

  // Main scenarios
  cov_invert_second: cover property (output_polarity_control[polarity_detect_pkg::second_pin_invert_bit] ##1
    second_general_pin != second_pin_source);
  cov_id_read: cover property (reg_read && reg_addr == polarity_detect_pkg::identification_offset);
  cov_incompatible: cover property (!pll_enabled && ratio_detect_in == 4'h4 ##1 clock_error);
  cov_status_read: cover property (reg_read && reg_addr == polarity_detect_pkg::detect_offset ##1
    reg_rdata != polarity_detect_pkg::read_zero);
  cov_over_limit: cover property (mclk_over_limit ##1 clock_error);
endmodule // output_polarity_clock_detect_regs

/* File: test/tb_output_polarity_clock_detect_regs.sv */
// Self-checking bench for the polarity, identification and clock detect registers
`timescale 1ns/100ps
module tb_output_polarity_clock_detect_regs;
  logic core_clk, reset_n, reg_write, reg_read, first_pin_source, second_pin_source, mute_source;
  logic pll_enabled, mclk_over_limit, first_general_pin, second_general_pin, mute_pin, clock_error;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] rate_detect_in;
  logic [3:0] ratio_detect_in;
  int err_count = 0;
  int samples_checked = 0;
  int mults [16] = '{0, 32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048, 3072, 0};
  localparam logic [7:0] id = polarity_detect_pkg::chip_identification_value;

  output_polarity_clock_detect_regs dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .first_pin_source(first_pin_source), .second_pin_source(second_pin_source), .mute_source(mute_source),
    .first_general_pin(first_general_pin), .second_general_pin(second_general_pin), .mute_pin(mute_pin),
    .rate_detect_in(rate_detect_in), .ratio_detect_in(ratio_detect_in), .pll_enabled(pll_enabled),
    .mclk_over_limit(mclk_over_limit), .clock_error(clock_error));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge core_clk);
    reg_read = 1'b0;
    check(name, exp, reg_rdata);
    @(negedge core_clk);
  endtask

  // Drives detector inputs, then reads the status register and the error flag
  task automatic status(input logic [2:0] r, input logic [3:0] q, input logic pll, input logic over);
    logic [2:0] er;
    logic [3:0] eq;
    logic ee;
    er = (r == 3'h7) ? 3'h0 : r;
    eq = (q == 4'hF) ? 4'h0 : q;
    ee = (er == 3'h0) || (eq == 4'h0) || over || (!pll && mults[eq] < polarity_detect_pkg::min_ratio_without_pll);
    rate_detect_in = r;
    ratio_detect_in = q;
    pll_enabled = pll;
    mclk_over_limit = over;
    @(negedge core_clk);
    rd(8'h5B, {1'b0, er, eq}, "status");
    check("clock_error", {7'h00, ee}, {7'h00, clock_error});
  endtask

  initial begin
    {reg_write, reg_read, first_pin_source, second_pin_source, mute_source, mclk_over_limit} = 6'h00;
    {reg_addr, reg_wdata, rate_detect_in, ratio_detect_in} = 23'h000000;
    pll_enabled = 1'b1;
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    rd(8'h57, 8'h00, "polarity reset");
    rd(8'h58, id, "identification");
    wr(8'h58, ~id);
    rd(8'h58, id, "identification after write");
    rd(8'h59, 8'h00, "unmapped");
    for (int p = 0; p < 8; p++) begin
      wr(8'h57, {2'b00, p[2:0], 3'b000});
      rd(8'h57, {2'b00, p[2:0], 3'b000}, "polarity");
      for (int s = 0; s < 8; s++) begin
        {second_pin_source, mute_source, first_pin_source} = s[2:0];
        @(negedge core_clk);
        @(negedge core_clk);
        check("pins", {5'h00, s[2:0] ^ p[2:0]}, {5'h00, second_general_pin, mute_pin, first_general_pin});
      end
    end
    wr(8'h57, 8'hC7);
    rd(8'h57, 8'hC7, "polarity reserved");
    for (int r = 0; r < 8; r++) for (int q = 0; q < 16; q++) status(r[2:0], q[3:0], 1'b1, 1'b0);
    for (int q = 0; q < 16; q++) status(3'h3, q[3:0], 1'b0, 1'b0);
    status(3'h3, 4'h6, 1'b1, 1'b1);
    wr(8'h5B, 8'hFF);
    status(3'h4, 4'hD, 1'b1, 1'b0);
    rd(8'h5B, 8'h4D, "status reread");
    // Reset in mid-run clears polarity, pins, flag and read data
    mclk_over_limit = 1'b1;
    @(negedge core_clk);
    check("clock_error over limit", 8'h01, {7'h00, clock_error});
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check("clock_error in reset", 8'h00, {7'h00, clock_error});
    check("pins in reset", 8'h00, {5'h00, second_general_pin, mute_pin, first_general_pin});
    check("read data in reset", 8'h00, reg_rdata);
    reset_n = 1'b1;
    rd(8'h57, 8'h00, "polarity after reset");
    give_verdict();
  end

  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end
endmodule // tb_output_polarity_clock_detect_regs
